// >>> hdl/sdsc_pkg.sv
/*
  Constants for the serial debug status/control block: field positions of the
  status/control byte, reset values, widths and mode state codes.
  Assumes it is compiled before every other file of the block.
*/
package sdsc_pkg;

  // ----------------------------------------
  // widths
  // ----------------------------------------
  localparam int STATUS_W = 8;
  localparam int ADDR_W = 16;

  // ----------------------------------------
  // status/control field positions
  // ----------------------------------------
  localparam int BIT_PERMIT = 7;
  localparam int BIT_ACTIVE = 6;
  localparam int BIT_BREAKPOINT_ENABLE = 5;
  localparam int BIT_FTS = 4;
  localparam int BIT_LINK_CLOCK_SELECT = 3;
  localparam int BIT_WS = 2;
  localparam int BIT_WSF = 1;
  localparam int BIT_DVF = 0;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic RST_PERMIT = 1'h0;
  localparam logic RST_BREAKPOINT_ENABLE = 1'h0;
  localparam logic RST_FTS = 1'h0;
  localparam logic RST_LINK_CLOCK_SELECT = 1'h0;
  localparam logic RST_FLAG = 1'h0;
  localparam logic [ADDR_W-1:0] RST_MATCH = 16'h0000;
  localparam logic [ADDR_W-1:0] RST_RSP = 16'h0000;
  localparam logic DVF_VALUE = 1'h0;

  // ----------------------------------------
  // cpu mode tracking
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_WAITSTOP = 3'h2,
    ST_ACTIVE = 3'h4
  } sdsc_mode_t;

endpackage

// >>> hdl/sdsc_match_compare.sv
/*
  Breakpoint address comparator: registers a hit when the cpu address bus
  equals the match address, and a separate hit for opcode fetch cycles.
  Assumes cpu bus signals are on the same clock as clk.
*/
`timescale 1ns/1ns
module sdsc_match_compare #(
  parameter int ADDR_W = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic [ADDR_W-1:0] match_addr,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic cpu_addr_valid,
  input wire logic cpu_opcode_fetch,
  output logic hit,
  output logic hit_fetch
);

  logic next_hit;
  logic next_hit_fetch;

  always_comb begin
    next_hit = enable && cpu_addr_valid && (cpu_addr == match_addr);
    next_hit_fetch = next_hit && cpu_opcode_fetch;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      hit <= 1'h0;
      hit_fetch <= 1'h0;
    end else begin
      hit <= next_hit;
      hit_fetch <= next_hit_fetch;
    end
  end

endmodule

// >>> hdl/sdsc_debug_status_control.sv
/*
  Status/control and breakpoint match registers of the serial debug
  controller. Registers are reached only through decoded serial commands.
  Assumes the serial command decoder and the cpu run on clk, issue at most
  one command strobe per cycle, and that the cpu reports mode changes.
*/
`timescale 1ns/1ns

// Overview of operation
// - 8-bit status and control register exists
// - 16-bit breakpoint match address register
// - no memory map access, commands only
// - status read and control write commands
// - permit bit locked while background active
// - permit clears on reset, gates background entry
// - four status bits are read only
// - active flag set during background mode
// - breakpoint disabled ignores select and match
// - force select: match forces at boundary
// - tag select: match tags fetched opcode
// - clock select resets 0, always writable
// - wait/stop status including halt from wait
// - halt command leaves wait or stop
// - wait/stop failure flag on failed access
// - slow access failure bit unused, zero
// - match register via breakpoint commands only
module sdsc_debug_status_control (
  input wire logic clk,
  input wire logic rstn,
  input wire logic status_read_cmd,
  input wire logic control_write_cmd,
  input wire logic breakpoint_read_cmd,
  input wire logic breakpoint_write_cmd,
  input wire logic halt_cmd,
  input wire logic mem_cmd_start,
  input wire logic [15:0] cmd_wdata,
  input wire logic [15:0] cpu_addr,
  input wire logic cpu_addr_valid,
  input wire logic cpu_opcode_fetch,
  input wire logic cpu_instr_boundary,
  input wire logic cpu_entered_bdm,
  input wire logic cpu_left_bdm,
  input wire logic cpu_wait_stop,
  input wire logic mem_wait_stop_fail,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic background_permit,
  output logic background_active_flag,
  output logic link_clock_select,
  output logic force_bkpt_req,
  output logic tag_bkpt_req,
  output logic halt_req
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  sdsc_pkg::sdsc_mode_t mode, next_mode;
  logic breakpoint_enable, next_breakpoint_enable;
  logic force_or_tag_select, next_force_or_tag_select;
  logic wait_stop_status, next_wait_stop_status;
  logic wait_stop_failure, next_wait_stop_failure;
  logic halted_from_ws, next_halted_from_ws;
  logic force_pending, next_force_pending;
  logic [sdsc_pkg::ADDR_W-1:0] debug_breakpoint_match, next_debug_breakpoint_match;
  logic next_rsp_valid;
  logic [15:0] next_rsp_data;
  logic next_background_permit;
  logic next_background_active_flag;
  logic next_link_clock_select;
  logic next_force_bkpt_req;
  logic next_tag_bkpt_req;
  logic next_halt_req;
  logic hit;
  logic hit_fetch;
  logic [sdsc_pkg::STATUS_W-1:0] debug_status_control;

  // ----------------------------------------
  // status byte assembly
  // ----------------------------------------
  always_comb begin
    debug_status_control = '0;
    debug_status_control[sdsc_pkg::BIT_PERMIT] = background_permit;
    debug_status_control[sdsc_pkg::BIT_ACTIVE] = background_active_flag;
    debug_status_control[sdsc_pkg::BIT_BREAKPOINT_ENABLE] = breakpoint_enable;
    debug_status_control[sdsc_pkg::BIT_FTS] = force_or_tag_select;
    debug_status_control[sdsc_pkg::BIT_LINK_CLOCK_SELECT] = link_clock_select;
    debug_status_control[sdsc_pkg::BIT_WS] = wait_stop_status;
    debug_status_control[sdsc_pkg::BIT_WSF] = wait_stop_failure;
    debug_status_control[sdsc_pkg::BIT_DVF] = sdsc_pkg::DVF_VALUE;
  end

  // ----------------------------------------
  // breakpoint comparator
  // ----------------------------------------
  sdsc_match_compare #(
    .ADDR_W(sdsc_pkg::ADDR_W)
  ) u_compare (
    .clk(clk),
    .rstn(rstn),
    .enable(breakpoint_enable),
    .match_addr(debug_breakpoint_match),
    .cpu_addr(cpu_addr),
    .cpu_addr_valid(cpu_addr_valid),
    .cpu_opcode_fetch(cpu_opcode_fetch),
    .hit(hit),
    .hit_fetch(hit_fetch)
  );

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb begin
    next_mode = mode;
    next_halted_from_ws = halted_from_ws;
    next_halt_req = 1'h0;
    case (mode)
      sdsc_pkg::ST_RUN: begin
        if (cpu_entered_bdm && background_permit) begin
          next_mode = sdsc_pkg::ST_ACTIVE;
        end else if (cpu_wait_stop) begin
          next_mode = sdsc_pkg::ST_WAITSTOP;
        end
        next_halt_req = halt_cmd && background_permit;
      end
      sdsc_pkg::ST_WAITSTOP: begin
        if (cpu_entered_bdm && background_permit) begin
          next_mode = sdsc_pkg::ST_ACTIVE;
          next_halted_from_ws = 1'h1;
        end else if (!cpu_wait_stop) begin
          next_mode = sdsc_pkg::ST_RUN;
        end
        next_halt_req = halt_cmd && background_permit;
      end
      sdsc_pkg::ST_ACTIVE: begin
        if (cpu_left_bdm) begin
          next_mode = sdsc_pkg::ST_RUN;
          next_halted_from_ws = 1'h0;
        end
      end
      default: begin
        next_mode = sdsc_pkg::ST_RUN;
        next_halted_from_ws = 1'h0;
      end
    endcase

    next_background_active_flag = (next_mode == sdsc_pkg::ST_ACTIVE);
    next_wait_stop_status = (next_mode == sdsc_pkg::ST_WAITSTOP) ||
      ((next_mode == sdsc_pkg::ST_ACTIVE) && next_halted_from_ws);

    // set wins over the clear at the start of a new access
    next_wait_stop_failure = wait_stop_failure;
    if (mem_cmd_start) begin
      next_wait_stop_failure = 1'h0;
    end
    if (mem_wait_stop_fail) begin
      next_wait_stop_failure = 1'h1;
    end

    // control write touches only writable bits
    next_background_permit = background_permit;
    next_breakpoint_enable = breakpoint_enable;
    next_force_or_tag_select = force_or_tag_select;
    next_link_clock_select = link_clock_select;
    if (control_write_cmd) begin
      if (mode != sdsc_pkg::ST_ACTIVE) begin
        next_background_permit = cmd_wdata[sdsc_pkg::BIT_PERMIT];
      end
      next_breakpoint_enable = cmd_wdata[sdsc_pkg::BIT_BREAKPOINT_ENABLE];
      next_force_or_tag_select = cmd_wdata[sdsc_pkg::BIT_FTS];
      next_link_clock_select = cmd_wdata[sdsc_pkg::BIT_LINK_CLOCK_SELECT];
    end

    next_debug_breakpoint_match = debug_breakpoint_match;
    if (breakpoint_write_cmd) begin
      next_debug_breakpoint_match = cmd_wdata;
    end

    // read answers, one cycle after the command
    next_rsp_valid = status_read_cmd || breakpoint_read_cmd;
    next_rsp_data = '0;
    if (status_read_cmd) begin
      next_rsp_data = {8'h00, debug_status_control};
    end else if (breakpoint_read_cmd) begin
      next_rsp_data = debug_breakpoint_match;
    end

    // force: hold a match until the next instruction boundary
    next_force_pending = force_pending;
    if (hit && breakpoint_enable && force_or_tag_select) begin
      next_force_pending = 1'h1;
    end
    next_force_bkpt_req = 1'h0;
    if (next_force_pending && cpu_instr_boundary && breakpoint_enable) begin
      next_force_bkpt_req = 1'h1;
      next_force_pending = 1'h0;
    end
    if (!breakpoint_enable || !force_or_tag_select || mode == sdsc_pkg::ST_ACTIVE) begin
      next_force_pending = 1'h0;
    end

    // tag: mark the fetched opcode; the cpu acts only if it is executed
    next_tag_bkpt_req = hit_fetch && breakpoint_enable && !force_or_tag_select;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode <= sdsc_pkg::ST_RUN;
      halted_from_ws <= sdsc_pkg::RST_FLAG;
      background_active_flag <= sdsc_pkg::RST_FLAG;
      wait_stop_status <= sdsc_pkg::RST_FLAG;
      wait_stop_failure <= sdsc_pkg::RST_FLAG;
      background_permit <= sdsc_pkg::RST_PERMIT;
      breakpoint_enable <= sdsc_pkg::RST_BREAKPOINT_ENABLE;
      force_or_tag_select <= sdsc_pkg::RST_FTS;
      link_clock_select <= sdsc_pkg::RST_LINK_CLOCK_SELECT;
      debug_breakpoint_match <= sdsc_pkg::RST_MATCH;
      rsp_valid <= sdsc_pkg::RST_FLAG;
      rsp_data <= sdsc_pkg::RST_RSP;
      force_pending <= sdsc_pkg::RST_FLAG;
      force_bkpt_req <= sdsc_pkg::RST_FLAG;
      tag_bkpt_req <= sdsc_pkg::RST_FLAG;
      halt_req <= sdsc_pkg::RST_FLAG;
    end else begin
      mode <= next_mode;
      halted_from_ws <= next_halted_from_ws;
      background_active_flag <= next_background_active_flag;
      wait_stop_status <= next_wait_stop_status;
      wait_stop_failure <= next_wait_stop_failure;
      background_permit <= next_background_permit;
      breakpoint_enable <= next_breakpoint_enable;
      force_or_tag_select <= next_force_or_tag_select;
      link_clock_select <= next_link_clock_select;
      debug_breakpoint_match <= next_debug_breakpoint_match;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      force_pending <= next_force_pending;
      force_bkpt_req <= next_force_bkpt_req;
      tag_bkpt_req <= next_tag_bkpt_req;
      halt_req <= next_halt_req;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_force_armed;
    hit && breakpoint_enable && force_or_tag_select && !cpu_instr_boundary &&
      mode != sdsc_pkg::ST_ACTIVE;
  endsequence

  sequence s_boundary_en;
    cpu_instr_boundary && breakpoint_enable && force_or_tag_select &&
      mode != sdsc_pkg::ST_ACTIVE;
  endsequence

  sequence s_ws_enter;
    mode == sdsc_pkg::ST_RUN && cpu_wait_stop && !cpu_entered_bdm;
  endsequence

  AST_PERMIT_LOCKED: assert property (
    control_write_cmd && background_active_flag |=> $stable(background_permit))
    else $error("permit changed while background active");

  AST_CTRL_WRITE: assert property (
    control_write_cmd && !background_active_flag |=>
      background_permit == $past(cmd_wdata[sdsc_pkg::BIT_PERMIT]) &&
      breakpoint_enable == $past(cmd_wdata[sdsc_pkg::BIT_BREAKPOINT_ENABLE]) &&
      force_or_tag_select == $past(cmd_wdata[sdsc_pkg::BIT_FTS]))
    else $error("control write did not update writable bits");

  AST_STATUS_READ: assert property (
    status_read_cmd |=> rsp_valid && rsp_data[7:0] == $past(debug_status_control))
    else $error("status read answer wrong");

  AST_STATUS_RO: assert property (
    control_write_cmd && !cpu_entered_bdm && !cpu_left_bdm && !cpu_wait_stop &&
      !mem_wait_stop_fail && !mem_cmd_start && mode == sdsc_pkg::ST_RUN |=>
      !background_active_flag && !wait_stop_status && $stable(wait_stop_failure))
    else $error("control write altered a status bit");

  AST_ACTIVE_SET: assert property (
    cpu_entered_bdm && background_permit && mode != sdsc_pkg::ST_ACTIVE |=>
      background_active_flag ##0 (background_active_flag || cpu_left_bdm) [*1])
    else $error("active flag not set on background entry");

  AST_BKPT_OFF: assert property (
    !breakpoint_enable [*3] |-> !force_bkpt_req && !tag_bkpt_req)
    else $error("breakpoint request while disabled");

  AST_FORCE: assert property (
    s_force_armed ##1 s_boundary_en |=> force_bkpt_req)
    else $error("force request missing at boundary");

  AST_FORCE_HELD: assert property (
    force_pending && s_boundary_en |=> force_bkpt_req)
    else $error("held force request missing at boundary");

  AST_TAG: assert property (
    hit_fetch && breakpoint_enable && !force_or_tag_select |=> tag_bkpt_req)
    else $error("tag request missing");

  AST_LINK_CLOCK_SELECT: assert property (
    control_write_cmd |=> link_clock_select == $past(cmd_wdata[sdsc_pkg::BIT_LINK_CLOCK_SELECT]))
    else $error("clock select not written");

  AST_WS: assert property (
    s_ws_enter |=> wait_stop_status)
    else $error("wait/stop status not shown");

  AST_HALT: assert property (
    halt_cmd && background_permit && mode == sdsc_pkg::ST_WAITSTOP |=> halt_req)
    else $error("halt not requested from wait/stop");

  AST_WSF: assert property (
    mem_wait_stop_fail |=> wait_stop_failure)
    else $error("wait/stop failure not flagged");

  AST_DVF: assert property (
    status_read_cmd |=> rsp_data[sdsc_pkg::BIT_DVF] == 1'h0)
    else $error("slow access failure bit not zero");

  AST_BKPT_RW: assert property (
    breakpoint_write_cmd ##1 breakpoint_read_cmd |=> rsp_valid &&
      rsp_data == $past(cmd_wdata, 2))
    else $error("breakpoint match readback wrong");

  AST_BKPT_GAP: assert property (
    breakpoint_write_cmd ##1 !breakpoint_write_cmd ##1 breakpoint_read_cmd |=>
      rsp_valid && rsp_data == $past(cmd_wdata, 3))
    else $error("breakpoint match readback wrong after gap");

endmodule

// >>> verification/sdsc_cpu_model.sv
/*
  Behavioural cpu beside the debug status/control block: enters active
  background mode on a halt, force or tag request and leaves it on resume.
  Assumes requests are one-cycle pulses on clk; slow adds a 3-cycle delay.
*/
`timescale 1ns/1ns
module sdsc_cpu_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic permit,
  input wire logic halt_req,
  input wire logic force_bkpt_req,
  input wire logic tag_bkpt_req,
  input wire logic slow,
  input wire logic resume,
  output logic cpu_entered_bdm,
  output logic cpu_left_bdm
);
  logic [2:0] cnt;
  logic in_bdm;

  // ----------------------------------------
  // mode tracking
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt <= 3'h0;
      in_bdm <= 1'h0;
      cpu_entered_bdm <= 1'h0;
      cpu_left_bdm <= 1'h0;
    end else begin
      cpu_entered_bdm <= 1'h0;
      cpu_left_bdm <= 1'h0;
      if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
        if (cnt == 3'h1) begin
          cpu_entered_bdm <= 1'h1;
          in_bdm <= 1'h1;
        end
      end else if (!in_bdm && permit && (halt_req || force_bkpt_req || tag_bkpt_req)) begin
        if (slow) begin
          cnt <= 3'h3;
        end else begin
          cpu_entered_bdm <= 1'h1;
          in_bdm <= 1'h1;
        end
      end else if (in_bdm && resume) begin
        cpu_left_bdm <= 1'h1;
        in_bdm <= 1'h0;
      end
    end
  end
endmodule

// >>> verification/tb_sdsc_debug_status_control.sv
/*
  Self-checking bench for the debug status/control block: command tasks,
  cpu bus stimulus and a cpu model answering background requests.
  Assumes the decoded command strobe interface of the design's top module.
*/
`timescale 1ns/1ns
module tb_sdsc_debug_status_control;
  logic clk, rstn, status_read_cmd, control_write_cmd, breakpoint_read_cmd;
  logic breakpoint_write_cmd, halt_cmd, mem_cmd_start, cpu_addr_valid, cpu_opcode_fetch;
  logic cpu_instr_boundary, cpu_entered_bdm, cpu_left_bdm, cpu_wait_stop, mem_wait_stop_fail;
  logic rsp_valid, background_permit, background_active_flag, link_clock_select;
  logic force_bkpt_req, tag_bkpt_req, halt_req, slow, resume;
  logic [15:0] cmd_wdata, cpu_addr, rsp_data;
  int n_errors = 0;
  int checked = 0;
  int n;

  sdsc_debug_status_control uut (.clk(clk), .rstn(rstn), .status_read_cmd(status_read_cmd),
    .control_write_cmd(control_write_cmd), .breakpoint_read_cmd(breakpoint_read_cmd),
    .breakpoint_write_cmd(breakpoint_write_cmd), .halt_cmd(halt_cmd),
    .mem_cmd_start(mem_cmd_start), .cmd_wdata(cmd_wdata), .cpu_addr(cpu_addr),
    .cpu_addr_valid(cpu_addr_valid), .cpu_opcode_fetch(cpu_opcode_fetch),
    .cpu_instr_boundary(cpu_instr_boundary), .cpu_entered_bdm(cpu_entered_bdm),
    .cpu_left_bdm(cpu_left_bdm), .cpu_wait_stop(cpu_wait_stop),
    .mem_wait_stop_fail(mem_wait_stop_fail), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .background_permit(background_permit), .background_active_flag(background_active_flag),
    .link_clock_select(link_clock_select), .force_bkpt_req(force_bkpt_req),
    .tag_bkpt_req(tag_bkpt_req), .halt_req(halt_req));

  sdsc_cpu_model cpu (.clk(clk), .rstn(rstn), .permit(background_permit),
    .halt_req(halt_req), .force_bkpt_req(force_bkpt_req), .tag_bkpt_req(tag_bkpt_req),
    .slow(slow), .resume(resume), .cpu_entered_bdm(cpu_entered_bdm),
    .cpu_left_bdm(cpu_left_bdm));

  // ----------------------------------------
  // clock and closing
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task close_out;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    close_out;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task wr(input logic bk, input logic [15:0] d);
    @(posedge clk);
    control_write_cmd <= ~bk;
    breakpoint_write_cmd <= bk;
    cmd_wdata <= d;
    @(posedge clk);
    control_write_cmd <= 1'h0;
    breakpoint_write_cmd <= 1'h0;
  endtask

  task rd(input logic bk, input logic [15:0] exp);
    @(posedge clk);
    status_read_cmd <= ~bk;
    breakpoint_read_cmd <= bk;
    @(posedge clk);
    status_read_cmd <= 1'h0;
    breakpoint_read_cmd <= 1'h0;
    #1;
    check("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
    check(bk ? "match" : "status", exp, rsp_data);
  endtask

  // sel: 0 halt, 1 boundary, 2 wait/stop fail, 3 mem start, 4 resume
  task pulse(input int sel);
    @(posedge clk);
    case (sel)
      0: halt_cmd <= 1'h1;
      1: cpu_instr_boundary <= 1'h1;
      2: mem_wait_stop_fail <= 1'h1;
      3: mem_cmd_start <= 1'h1;
      default: resume <= 1'h1;
    endcase
    @(posedge clk);
    {halt_cmd, cpu_instr_boundary, mem_wait_stop_fail, mem_cmd_start, resume} <= 5'h00;
  endtask

  task drive_addr(input logic fetch);
    @(posedge clk);
    cpu_addr <= 16'hA5C3;
    cpu_addr_valid <= 1'h1;
    cpu_opcode_fetch <= fetch;
    @(posedge clk);
    cpu_addr <= 16'h0000;
    cpu_addr_valid <= 1'h0;
    cpu_opcode_fetch <= 1'h0;
  endtask

  // sel: 0 halt_req, 1 force, 2 tag, 3 active high, 4 active low
  task wait_for(input int sel, input int lim, input logic exp, input string name);
    int i;
    logic s;
    n = 0;
    for (i = 1; i <= lim && n == 0; i++) begin
      #1;
      case (sel)
        0: s = halt_req;
        1: s = force_bkpt_req;
        2: s = tag_bkpt_req;
        3: s = background_active_flag;
        default: s = ~background_active_flag;
      endcase
      if (s === 1'h1) n = i;
      else @(posedge clk);
    end
    check(name, {15'h0000, exp}, {15'h0000, n != 0});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rstn, status_read_cmd, control_write_cmd, breakpoint_read_cmd} = 4'h0;
    {breakpoint_write_cmd, halt_cmd, mem_cmd_start, cpu_addr_valid} = 4'h0;
    {cpu_opcode_fetch, cpu_instr_boundary, cpu_wait_stop, mem_wait_stop_fail} = 4'h0;
    {slow, resume} = 2'h0;
    cmd_wdata = 16'h0000;
    cpu_addr = 16'h0000;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    rd(1'h0, 16'h0000);
    rd(1'h1, 16'h0000);
    wr(1'h0, 16'h00FF);
    rd(1'h0, 16'h00B8);
    check("permit", 16'h0001, {15'h0000, background_permit});
    check("clock_select", 16'h0001, {15'h0000, link_clock_select});
    wr(1'h0, 16'h00B0);
    wr(1'h1, 16'hA5C3);
    rd(1'h1, 16'hA5C3);
    rd(1'h0, 16'h00B0);
    check("clock_select", 16'h0000, {15'h0000, link_clock_select});
    drive_addr(1'h0);
    wait_for(1, 3, 1'h0, "force_early");
    pulse(1);
    wait_for(1, 3, 1'h1, "force_req");
    wait_for(3, 6, 1'h1, "active_up");
    rd(1'h0, 16'h00F0);
    wr(1'h0, 16'h0038);
    rd(1'h0, 16'h00F8);
    pulse(4);
    wait_for(4, 6, 1'h1, "active_down");
    rd(1'h0, 16'h00B8);
    wr(1'h0, 16'h00A0);
    slow <= 1'h1;
    drive_addr(1'h1);
    wait_for(2, 4, 1'h1, "tag_req");
    wait_for(3, 8, 1'h1, "active_up");
    pulse(4);
    wait_for(4, 6, 1'h1, "active_down");
    slow <= 1'h0;
    wr(1'h0, 16'h0090);
    drive_addr(1'h1);
    pulse(1);
    wait_for(1, 4, 1'h0, "force_off");
    wait_for(2, 1, 1'h0, "tag_off");
    cpu_wait_stop <= 1'h1;
    rd(1'h0, 16'h0094);
    pulse(2);
    rd(1'h0, 16'h0096);
    pulse(0);
    wait_for(0, 3, 1'h1, "halt_req");
    wait_for(3, 6, 1'h1, "active_up");
    cpu_wait_stop <= 1'h0;
    rd(1'h0, 16'h00D6);
    pulse(3);
    rd(1'h0, 16'h00D4);
    pulse(4);
    wait_for(4, 6, 1'h1, "active_down");
    rd(1'h0, 16'h0090);
    wr(1'h0, 16'h0000);
    pulse(0);
    wait_for(0, 4, 1'h0, "halt_off");
    rd(1'h0, 16'h0000);
    wr(1'h0, 16'h00FF);
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    rd(1'h0, 16'h0000);
    check("permit_after_reset", 16'h0000, {15'h0000, background_permit});
    close_out;
  end
endmodule
